// ===== shared/dlp_pkg.sv
package dlp_pkg;
    // counter and accumulator widths
    localparam int CNT_W_DEF     = 32;
    localparam int LINE_ACC_W    = 11;
    localparam int PATH_ACC_W    = 9;
    localparam int RUN_W         = 4;
    // per-second classification limits
    localparam logic [LINE_ACC_W-1:0] LINE_SES_ANOM = 11'h608; // 1544
    localparam logic [PATH_ACC_W-1:0] ESF_SES_CRC   = 9'h140;  // 320
    localparam logic [PATH_ACC_W-1:0] SF_SES_FBE    = 9'h004;  // four
    // unavailability entry and exit run length
    localparam logic [RUN_W-1:0]      UA_RUN_LEN    = 4'ha;    // ten
    localparam logic [RUN_W-1:0]      RUN_ZERO      = 4'h0;
    localparam logic [RUN_W-1:0]      RUN_ONE       = 4'h1;
    typedef enum logic [1:0] {
        DLP_ST_AVAIL   = 2'b01,
        DLP_ST_UNAVAIL = 2'b10
    } dlp_ua_state_t;
endpackage : dlp_pkg

// ===== shared/dlp_sec_if.sv
`timescale 1ns/1ps
interface dlp_sec_if;
    import dlp_pkg::*;
    logic             tick;
    logic             ses;
    logic             es;
    logic             upd;
    logic             unavail;
    logic [RUN_W-1:0] uas_add;
    logic [RUN_W-1:0] uas_sub;
    logic [RUN_W-1:0] es_add;
    logic [RUN_W-1:0] ses_add;
    modport pm (output tick, ses, es,
                input  upd, unavail, uas_add, uas_sub, es_add, ses_add);
    modport ua (input  tick, ses, es,
                output upd, unavail, uas_add, uas_sub, es_add, ses_add);
endinterface : dlp_sec_if

// ===== core/dlp_unavail.sv
`timescale 1ns/1ps
module dlp_unavail
    import dlp_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // per-second classification and counter deltas
    dlp_sec_if.ua     sec
);
    dlp_ua_state_t    state_q;
    logic [RUN_W-1:0] run_q;
    logic [RUN_W-1:0] pend_es_q;
    logic [RUN_W-1:0] pend_ses_q;
    logic [RUN_W-1:0] run_inc;
    logic [RUN_W-1:0] es_one;

    assign run_inc = run_q + RUN_ONE;
    assign es_one  = sec.es ? RUN_ONE : RUN_ZERO;
    assign sec.unavail = (state_q == DLP_ST_UNAVAIL);

    // pending seconds stay uncommitted until the run resolves either way
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q     <= DLP_ST_AVAIL;
            run_q       <= RUN_ZERO;
            pend_es_q   <= RUN_ZERO;
            pend_ses_q  <= RUN_ZERO;
            sec.upd     <= 1'b0;
            sec.uas_add <= RUN_ZERO;
            sec.uas_sub <= RUN_ZERO;
            sec.es_add  <= RUN_ZERO;
            sec.ses_add <= RUN_ZERO;
        end else begin
            sec.upd     <= sec.tick;
            sec.uas_add <= RUN_ZERO;
            sec.uas_sub <= RUN_ZERO;
            sec.es_add  <= RUN_ZERO;
            sec.ses_add <= RUN_ZERO;
            if (sec.tick) begin
                case (state_q)
                    DLP_ST_AVAIL: begin
                        if (sec.ses) begin
                            if (run_inc == UA_RUN_LEN) begin
                                state_q     <= DLP_ST_UNAVAIL;
                                sec.uas_add <= UA_RUN_LEN;
                                run_q       <= RUN_ZERO;
                                pend_es_q   <= RUN_ZERO;
                                pend_ses_q  <= RUN_ZERO;
                            end else begin
                                run_q      <= run_inc;
                                pend_es_q  <= pend_es_q + RUN_ONE;
                                pend_ses_q <= pend_ses_q + RUN_ONE;
                            end
                        end else begin
                            sec.es_add  <= pend_es_q + es_one;
                            sec.ses_add <= pend_ses_q;
                            run_q       <= RUN_ZERO;
                            pend_es_q   <= RUN_ZERO;
                            pend_ses_q  <= RUN_ZERO;
                        end
                    end
                    DLP_ST_UNAVAIL: begin
                        sec.uas_add <= RUN_ONE;
                        if (sec.ses) begin
                            run_q     <= RUN_ZERO;
                            pend_es_q <= RUN_ZERO;
                        end else if (run_inc == UA_RUN_LEN) begin
                            state_q     <= DLP_ST_AVAIL;
                            sec.uas_sub <= UA_RUN_LEN;
                            sec.es_add  <= pend_es_q + es_one;
                            run_q       <= RUN_ZERO;
                            pend_es_q   <= RUN_ZERO;
                        end else begin
                            run_q     <= run_inc;
                            pend_es_q <= pend_es_q + es_one;
                        end
                    end
                    default: begin
                        state_q <= DLP_ST_AVAIL;
                        run_q   <= RUN_ZERO;
                    end
                endcase
            end
        end
    end

    default clocking ua_cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    enter_unavail_a: assert property (
        sec.tick && !sec.unavail && sec.ses && run_q == 4'h9
        |=> sec.unavail && sec.uas_add == 4'ha)
        else $error("path did not enter unavailable after ten severe seconds");
    leave_unavail_a: assert property (
        sec.tick && sec.unavail && !sec.ses && run_q == 4'h9
        |=> !sec.unavail && sec.uas_sub == 4'ha && sec.uas_add == 4'h1)
        else $error("path did not leave unavailable after ten clean seconds");
    uas_count_a: assert property (
        sec.tick && sec.unavail |=> sec.upd && sec.uas_add == 4'h1)
        else $error("unavailable second not counted");
    suppress_es_a: assert property (
        sec.tick && sec.ses |=> sec.ses_add == 4'h0)
        else $error("severe second committed while pending");
    enter_c: cover property (sec.tick && sec.ses ##1 sec.unavail);
    leave_c: cover property (sec.unavail ##1 !sec.unavail);
endmodule : dlp_unavail

// ===== core/dlp_pm.sv
// Operation
// - count each bipolar violation and each excessive-zeros event as line code violation
// - line errored second: any line anomaly or loss of signal
// - line severe second: 1544 or more anomalies, or loss of signal
// - loss-of-signal second: any loss-of-signal defect during the second
// - path alarm second: any alarm indication defect during the second
// - ESF framing: path code violation per CRC-6 error
// - SF framing: path code violation per frame bit error
// - ESF errored second: CRC-6 error, slip, severe-frame or alarm defect
// - SF errored second: frame bit error, slip, severe-frame or alarm defect
// - frame/alarm severe second: any severe-frame or alarm defect
// - ESF severe second: 320 or more CRC-6 errors, or severe-frame/alarm
// - SF severe second: four frame bit errors, or severe-frame/alarm
// - path goes unavailable after ten consecutive severe seconds
// - those ten severe seconds are added to unavailable seconds
// - path returns available after ten consecutive non-severe seconds
// - those ten clean seconds are removed from unavailable seconds
// - every unavailable second increments unavailable seconds
// - path CV, ES, SES and UAS counters compared against software-set thresholds
// - no far-end path counters; near-end line and receive path only
`timescale 1ns/1ps
module dlp_pm
    import dlp_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // timebase and framing mode
    input  wire logic             sec_tick_in,
    input  wire logic             esf_mode_in,
    // line anomalies and defects
    input  wire logic             line_bpv_in,
    input  wire logic             line_exz_in,
    input  wire logic             line_los_in,
    // path anomalies and defects
    input  wire logic             path_crc_err_in,
    input  wire logic             frame_bit_error_in,
    input  wire logic             path_slip_in,
    input  wire logic             severely_errored_frame_defect_in,
    input  wire logic             path_ais_in,
    // path thresholds, zero disables
    input  wire logic [CNT_W-1:0] cv_thresh_in,
    input  wire logic [CNT_W-1:0] es_thresh_in,
    input  wire logic [CNT_W-1:0] ses_thresh_in,
    input  wire logic [CNT_W-1:0] uas_thresh_in,
    // line counters
    output logic      [CNT_W-1:0] line_code_violation_count_out,
    output logic      [CNT_W-1:0] line_errored_seconds_out,
    output logic      [CNT_W-1:0] line_severe_errored_seconds_out,
    output logic      [CNT_W-1:0] line_los_seconds_out,
    // path counters
    output logic      [CNT_W-1:0] path_alarm_indication_seconds_out,
    output logic      [CNT_W-1:0] path_code_violation_count_out,
    output logic      [CNT_W-1:0] path_errored_seconds_out,
    output logic      [CNT_W-1:0] path_frame_alarm_severe_seconds_out,
    output logic      [CNT_W-1:0] path_severe_errored_seconds_out,
    output logic      [CNT_W-1:0] path_unavailable_seconds_out,
    // status
    output logic                  path_unavail_out,
    output logic      [3:0]       thresh_over_out
);
    if (CNT_W < 12 || CNT_W > 64) begin : g_bad_width
        $error("CNT_W must lie between 12 and 64");
    end

    dlp_sec_if sec_if ();

    // latched over the current second
    logic [LINE_ACC_W-1:0] line_anom_q;
    logic [PATH_ACC_W-1:0] path_err_q;
    logic                  los_seen_q;
    logic                  ais_seen_q;
    logic                  sfd_seen_q;
    logic                  slip_seen_q;
    // counters
    logic [CNT_W-1:0]      line_cv_q;
    logic [CNT_W-1:0]      line_es_q;
    logic [CNT_W-1:0]      line_ses_q;
    logic [CNT_W-1:0]      line_los_q;
    logic [CNT_W-1:0]      path_ais_q;
    logic [CNT_W-1:0]      path_cv_q;
    logic [CNT_W-1:0]      path_es_q;
    logic [CNT_W-1:0]      path_sas_q;
    logic [CNT_W-1:0]      path_ses_q;
    logic [CNT_W-1:0]      path_uas_q;
    logic [3:0]            over_q;
    // combinational view of the second, including this cycle's events
    logic [1:0]            anom_inc;
    logic                  path_err_ev;
    logic [LINE_ACC_W:0]   line_anom_sum;
    logic [LINE_ACC_W-1:0] line_anom_d;
    logic [PATH_ACC_W:0]   path_err_sum;
    logic [PATH_ACC_W-1:0] path_err_d;
    logic [PATH_ACC_W-1:0] path_ses_lim;
    logic                  los_sec;
    logic                  ais_sec;
    logic                  sfd_sec;
    logic                  line_es_sec;
    logic                  line_ses_sec;
    logic                  path_es_sec;
    logic                  path_ses_sec;
    logic [CNT_W-1:0]      thr [4];
    logic [CNT_W-1:0]      cnt [4];

    assign anom_inc    = {1'b0, line_bpv_in} + {1'b0, line_exz_in};
    assign path_err_ev = esf_mode_in ? path_crc_err_in : frame_bit_error_in;

    // accumulators saturate at the line and ESF severe limits; nothing beyond them matters
    always_comb begin
        line_anom_sum = {1'b0, line_anom_q} + {{(LINE_ACC_W-1){1'b0}}, anom_inc};
        if (line_anom_sum >= {1'b0, LINE_SES_ANOM}) begin
            line_anom_d = LINE_SES_ANOM;
        end else begin
            line_anom_d = line_anom_sum[LINE_ACC_W-1:0];
        end
        path_err_sum = {1'b0, path_err_q} + {{PATH_ACC_W{1'b0}}, path_err_ev};
        if (path_err_sum >= {1'b0, ESF_SES_CRC}) begin
            path_err_d = ESF_SES_CRC;
        end else begin
            path_err_d = path_err_sum[PATH_ACC_W-1:0];
        end
    end

    assign path_ses_lim = esf_mode_in ? ESF_SES_CRC : SF_SES_FBE;
    assign los_sec      = los_seen_q | line_los_in;
    assign ais_sec      = ais_seen_q | path_ais_in;
    assign sfd_sec      = sfd_seen_q | severely_errored_frame_defect_in;
    assign line_es_sec  = (line_anom_d != '0) | los_sec;
    assign line_ses_sec = (line_anom_d >= LINE_SES_ANOM) | los_sec;
    // slip and defects count alike in both framings
    assign path_es_sec  = (path_err_d != '0) | slip_seen_q | path_slip_in
                        | sfd_sec | ais_sec;
    assign path_ses_sec = (path_err_d >= path_ses_lim) | sfd_sec | ais_sec;

    assign sec_if.tick = sec_tick_in;
    assign sec_if.ses  = path_ses_sec;
    assign sec_if.es   = path_es_sec;

    dlp_unavail u_unavail (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .sec      (sec_if.ua)
    );

    // per-second latches; an event in the tick cycle is folded into that second
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            line_anom_q <= '0;
            path_err_q  <= '0;
            los_seen_q  <= 1'b0;
            ais_seen_q  <= 1'b0;
            sfd_seen_q  <= 1'b0;
            slip_seen_q <= 1'b0;
        end else if (sec_tick_in) begin
            line_anom_q <= '0;
            path_err_q  <= '0;
            los_seen_q  <= 1'b0;
            ais_seen_q  <= 1'b0;
            sfd_seen_q  <= 1'b0;
            slip_seen_q <= 1'b0;
        end else begin
            line_anom_q <= line_anom_d;
            path_err_q  <= path_err_d;
            los_seen_q  <= los_sec;
            ais_seen_q  <= ais_sec;
            sfd_seen_q  <= sfd_sec;
            slip_seen_q <= slip_seen_q | path_slip_in;
        end
    end

    // line counters
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            line_cv_q  <= '0;
            line_es_q  <= '0;
            line_ses_q <= '0;
            line_los_q <= '0;
        end else begin
            line_cv_q <= line_cv_q + CNT_W'(anom_inc);
            if (sec_tick_in) begin
                line_es_q  <= line_es_q + CNT_W'(line_es_sec);
                line_ses_q <= line_ses_q + CNT_W'(line_ses_sec);
                line_los_q <= line_los_q + CNT_W'(los_sec);
            end
        end
    end

    // near-end path counters only; far-end path reports are not kept
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            path_cv_q  <= '0;
            path_ais_q <= '0;
            path_sas_q <= '0;
        end else begin
            path_cv_q <= path_cv_q + CNT_W'(path_err_ev);
            if (sec_tick_in) begin
                path_ais_q <= path_ais_q + CNT_W'(ais_sec);
                path_sas_q <= path_sas_q + CNT_W'(sfd_sec | ais_sec);
            end
        end
    end

    // deltas arrive one cycle after the tick; the run decides commit or drop
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            path_es_q  <= '0;
            path_ses_q <= '0;
            path_uas_q <= '0;
        end else if (sec_if.upd) begin
            path_es_q  <= path_es_q + CNT_W'(sec_if.es_add);
            path_ses_q <= path_ses_q + CNT_W'(sec_if.ses_add);
            path_uas_q <= path_uas_q + CNT_W'(sec_if.uas_add)
                        - CNT_W'(sec_if.uas_sub);
        end
    end

    assign thr[0] = cv_thresh_in;
    assign thr[1] = es_thresh_in;
    assign thr[2] = ses_thresh_in;
    assign thr[3] = uas_thresh_in;
    assign cnt[0] = path_cv_q;
    assign cnt[1] = path_es_q;
    assign cnt[2] = path_ses_q;
    assign cnt[3] = path_uas_q;

    // crossing flags follow the counters a cycle late
    for (genvar i = 0; i < 4; i++) begin : g_thr
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                over_q[i] <= 1'b0;
            end else begin
                over_q[i] <= (thr[i] != '0) && (cnt[i] >= thr[i]);
            end
        end
    end

    assign line_code_violation_count_out       = line_cv_q;
    assign line_errored_seconds_out            = line_es_q;
    assign line_severe_errored_seconds_out     = line_ses_q;
    assign line_los_seconds_out                = line_los_q;
    assign path_alarm_indication_seconds_out   = path_ais_q;
    assign path_code_violation_count_out       = path_cv_q;
    assign path_errored_seconds_out            = path_es_q;
    assign path_frame_alarm_severe_seconds_out = path_sas_q;
    assign path_severe_errored_seconds_out     = path_ses_q;
    assign path_unavailable_seconds_out        = path_uas_q;
    assign path_unavail_out                    = sec_if.unavail;
    assign thresh_over_out                     = over_q;

    default clocking pm_cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    line_cv_inc_a: assert property (
        line_bpv_in && line_exz_in |=> line_cv_q == $past(line_cv_q) + 2)
        else $error("line code violation count not advanced by two");
    line_es_sec_a: assert property (
        sec_tick_in && line_bpv_in |=> line_es_q == $past(line_es_q) + 1)
        else $error("line errored second missed");
    line_ses_los_a: assert property (
        sec_tick_in && line_los_in |=> line_ses_q == $past(line_ses_q) + 1)
        else $error("line severe second missed on loss of signal");
    los_sec_a: assert property (
        line_los_in && !sec_tick_in ##1 !sec_tick_in ##1 sec_tick_in
        |=> line_los_q == $past(line_los_q) + 1)
        else $error("loss-of-signal second missed");
    ais_sec_a: assert property (
        sec_tick_in && !ais_seen_q && !path_ais_in |=> $stable(path_ais_q))
        else $error("alarm second counted without alarm");
    path_cv_esf_a: assert property (
        esf_mode_in && path_crc_err_in |=> path_cv_q == $past(path_cv_q) + 1)
        else $error("CRC-6 error not counted");
    path_cv_sf_a: assert property (
        !esf_mode_in && frame_bit_error_in && !path_crc_err_in
        |=> path_cv_q == $past(path_cv_q) + 1)
        else $error("frame bit error not counted");
    sf_ses_a: assert property (
        sec_tick_in && !esf_mode_in && path_err_q >= SF_SES_FBE
        |-> path_ses_sec)
        else $error("fourth frame bit error not severe");
    sas_sec_a: assert property (
        sec_tick_in && (sfd_seen_q || severely_errored_frame_defect_in)
        |=> path_sas_q == $past(path_sas_q) + 1)
        else $error("frame/alarm severe second missed");
    flag_clear_a: assert property (
        sec_tick_in |=> line_anom_q == '0 && !los_seen_q && path_err_q == '0)
        else $error("per-second flags not cleared on tick");
    thr_over_a: assert property (
        cv_thresh_in != '0 && path_cv_q >= cv_thresh_in |=> thresh_over_out[0])
        else $error("code violation threshold crossing not flagged");

    // tick-cycle checks read the latches, which still hold the second being closed
    line_cv_idle_a: assert property (
        !line_bpv_in && !line_exz_in |=> $stable(line_cv_q))
        else $error("line code violation count moved without event");
    line_ses_cnt_a: assert property (
        sec_tick_in && line_anom_q == LINE_SES_ANOM |=> line_ses_q == $past(line_ses_q) + 1)
        else $error("line severe second missed on anomaly count");
    ais_cnt_a: assert property (
        sec_tick_in && ais_seen_q |=> path_ais_q == $past(path_ais_q) + 1)
        else $error("alarm second missed");
    cv_esf_idle_a: assert property (
        esf_mode_in && !path_crc_err_in |=> $stable(path_cv_q))
        else $error("path code violation counted without CRC-6 error");
    cv_sf_idle_a: assert property (
        !esf_mode_in && !frame_bit_error_in |=> $stable(path_cv_q))
        else $error("path code violation counted without frame bit error");
    es_slip_a: assert property (
        sec_tick_in && slip_seen_q |-> path_es_sec)
        else $error("slip second not errored");
    esf_ses_a: assert property (
        sec_tick_in && esf_mode_in && path_err_q >= ESF_SES_CRC |-> path_ses_sec)
        else $error("second at the CRC-6 limit not severe");
    esf_below_a: assert property (
        sec_tick_in && esf_mode_in && path_err_q == 9'h13f && !path_crc_err_in
        && !sfd_sec && !ais_sec |-> !path_ses_sec)
        else $error("second below the CRC-6 limit taken as severe");
    sas_ais_a: assert property (
        sec_tick_in && ais_seen_q |=> path_sas_q == $past(path_sas_q) + 1)
        else $error("alarm second missing from frame/alarm severe seconds");
    commit_hold_a: assert property (
        !sec_if.upd |=> $stable(path_es_q) && $stable(path_ses_q) && $stable(path_uas_q))
        else $error("path second counters moved outside an update");
    unavail_quiet_a: assert property (
        sec_if.upd && path_unavail_out |-> sec_if.es_add == 4'h0 && sec_if.ses_add == 4'h0)
        else $error("errored second committed while unavailable");
    uas_thr_a: assert property (
        uas_thresh_in != '0 && path_uas_q >= uas_thresh_in |=> thresh_over_out[3])
        else $error("unavailable threshold crossing not flagged");
    thr_below_a: assert property (
        cv_thresh_in != '0 && path_cv_q < cv_thresh_in |=> !thresh_over_out[0])
        else $error("code violation threshold flagged too early");
    tick_clear_a: assert property (
        sec_tick_in |=> !ais_seen_q && !sfd_seen_q && !slip_seen_q)
        else $error("defect latches not cleared on tick");
    line_ses_c: cover property (sec_tick_in && line_anom_d == LINE_SES_ANOM);
    esf_ses_c:  cover property (sec_tick_in && esf_mode_in && path_err_d == ESF_SES_CRC);
    unavail_c:  cover property (path_unavail_out ##1 !path_unavail_out);
endmodule : dlp_pm

// ===== tb/dlp_src_model.sv
`timescale 1ns/1ps
module dlp_src_model (
    // clock
    input  wire logic clk_in,
    // anomaly and defect strobes toward the monitor
    output logic      bpv_out,
    output logic      exz_out,
    output logic      los_out,
    output logic      crc_out,
    output logic      fbit_out,
    output logic      slip_out,
    output logic      sfd_out,
    output logic      ais_out
);
    // bit order: bpv exz los crc fbit slip sfd ais
    logic [7:0] lines_q;

    assign {bpv_out, exz_out, los_out, crc_out, fbit_out, slip_out, sfd_out, ais_out} = lines_q;

    initial lines_q = 8'h00;

    // one event per cycle held high; changes only after a falling edge so the
    // monitor never samples a line mid-change
    task automatic drive(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            lines_q = v;
        end
        @(negedge clk_in);
        lines_q = 8'h00;
    endtask : drive
endmodule : dlp_src_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dlp_pkg::*;
    localparam int W = 16;
    logic         clk_in      = 1'b0;
    logic         reset_in    = 1'b1;
    logic         sec_tick_in = 1'b0;
    logic         esf_mode_in = 1'b1;
    logic         bpv, exz, los, crc, fbit, slip, sfd, ais;
    logic [W-1:0] thr [4]     = '{16'h013f, 16'h0064, 16'h0002, 16'h000a};
    logic [W-1:0] cnt [10];
    logic [W-1:0] exp_q [10]  = '{default: 16'h0000};
    logic         unavail;
    logic [3:0]   over;
    int           num_errors  = 0;
    int           check_count = 0;
    int           cycles      = 0;
    string        names [10]  = '{"line_cv", "line_es", "line_ses", "line_los", "path_ais",
                                  "path_cv", "path_es", "path_sas", "path_ses", "path_uas"};

    always #25 clk_in = ~clk_in;

    dlp_src_model src (.clk_in(clk_in), .bpv_out(bpv), .exz_out(exz), .los_out(los),
        .crc_out(crc), .fbit_out(fbit), .slip_out(slip), .sfd_out(sfd), .ais_out(ais));

    dlp_pm #(.CNT_W(W)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .sec_tick_in(sec_tick_in),
        .esf_mode_in(esf_mode_in), .line_bpv_in(bpv), .line_exz_in(exz), .line_los_in(los),
        .path_crc_err_in(crc), .frame_bit_error_in(fbit), .path_slip_in(slip),
        .severely_errored_frame_defect_in(sfd), .path_ais_in(ais),
        .cv_thresh_in(thr[0]), .es_thresh_in(thr[1]), .ses_thresh_in(thr[2]),
        .uas_thresh_in(thr[3]),
        .line_code_violation_count_out(cnt[0]), .line_errored_seconds_out(cnt[1]),
        .line_severe_errored_seconds_out(cnt[2]), .line_los_seconds_out(cnt[3]),
        .path_alarm_indication_seconds_out(cnt[4]), .path_code_violation_count_out(cnt[5]),
        .path_errored_seconds_out(cnt[6]), .path_frame_alarm_severe_seconds_out(cnt[7]),
        .path_severe_errored_seconds_out(cnt[8]), .path_unavailable_seconds_out(cnt[9]),
        .path_unavail_out(unavail), .thresh_over_out(over));

    task automatic check(input string name, input logic [W-1:0] seen, input logic [W-1:0] expv);
        check_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    task automatic check_all();
        for (int i = 0; i < 10; i++) check(names[i], cnt[i], exp_q[i]);
    endtask : check_all

    // path counters land two cycles after the tick, so three is enough margin
    task automatic tick();
        @(negedge clk_in);
        sec_tick_in = 1'b1;
        @(negedge clk_in);
        sec_tick_in = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask : tick

    task automatic t_line_events();
        src.drive(8'hc0, 3);
        exp_q[0] += 6;
        tick();
        exp_q[1] += 1;
        check_all();
        src.drive(8'h20, 1);
        tick();
        exp_q[1] += 1; exp_q[2] += 1; exp_q[3] += 1;
        check_all();
    endtask : t_line_events

    task automatic t_line_ses();
        src.drive(8'hc0, 772);
        tick();
        exp_q[0] += 1544; exp_q[1] += 1; exp_q[2] += 1;
        check_all();
        src.drive(8'h80, 1543);
        tick();
        exp_q[0] += 1543; exp_q[1] += 1;
        check_all();
    endtask : t_line_ses

    task automatic t_path_esf();
        src.drive(8'h18, 319);
        exp_q[5] += 319;
        tick();
        exp_q[6] += 1;
        check_all();
        src.drive(8'h10, 320);
        exp_q[5] += 320;
        tick();
        check_all();
        tick();
        exp_q[6] += 1; exp_q[8] += 1;
        check_all();
    endtask : t_path_esf

    task automatic t_path_sf();
        @(negedge clk_in);
        esf_mode_in = 1'b0;
        src.drive(8'h18, 3);
        exp_q[5] += 3;
        tick();
        exp_q[6] += 1;
        check_all();
        src.drive(8'h08, 4);
        exp_q[5] += 4;
        tick();
        tick();
        exp_q[6] += 1; exp_q[8] += 1;
        check_all();
        src.drive(8'h04, 1);
        tick();
        exp_q[6] += 1;
        check_all();
        src.drive(8'h01, 1);
        tick();
        tick();
        exp_q[4] += 1; exp_q[7] += 1; exp_q[6] += 1; exp_q[8] += 1;
        check_all();
    endtask : t_path_sf

    task automatic t_unavail();
        for (int i = 0; i < 10; i++) begin
            src.drive(8'h02, 1);
            tick();
            if (i == 8) check("unavail_early", {15'h0000, unavail}, 16'h0000);
        end
        exp_q[7] += 10; exp_q[9] += 10;
        check_all();
        check("unavail_set", {15'h0000, unavail}, 16'h0001);
        for (int i = 0; i < 9; i++) begin
            tick();
            exp_q[9] += 1;
        end
        check_all();
        check("unavail_hold", {15'h0000, unavail}, 16'h0001);
        tick();
        exp_q[9] -= 9;
        check_all();
        check("unavail_clear", {15'h0000, unavail}, 16'h0000);
        repeat (2) @(negedge clk_in);
        check("thresh_over", {12'h000, over}, 16'h000d);
    endtask : t_unavail

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // whole run is well under ten thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(negedge clk_in);
        reset_in = 1'b0;
        check_all();
        t_line_events();
        t_line_ses();
        t_path_esf();
        t_path_sf();
        t_unavail();
        print_verdict();
    end
endmodule : testbench
